// *** verilog/serial_ctrl_pkg.sv ***
package serial_ctrl_pkg;

    localparam logic [3:0] ADDR_CTRL     = 4'h0;
    localparam logic [3:0] ADDR_MODE     = 4'h1;
    localparam logic [3:0] ADDR_SC_MODE  = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
    localparam logic [3:0] ADDR_IRQ_CLR  = 4'h4;
    localparam logic [3:0] ADDR_IRQ_EN   = 4'h5;
    localparam logic [3:0] ADDR_PIN_STAT = 4'h6;

    // Control register fields
    localparam int CTRL_TX_IRQ_EN   = 7;
    localparam int CTRL_RX_IRQ_EN   = 6;
    localparam int CTRL_TX_EN       = 5;
    localparam int CTRL_RX_EN       = 4;
    localparam int CTRL_WAKE_EN     = 3;
    localparam int CTRL_TX_DONE_EN  = 2;
    localparam int CTRL_CLK_SEL_HI  = 1;
    localparam int CTRL_CLK_SEL_LO  = 0;

    // Mode and smart card mode register fields
    localparam int MODE_SYNC        = 7;
    localparam int MODE_BLOCK_XFER  = 6;
    localparam int MODE_MULTIPROC   = 2;
    localparam int SC_MODE_SELECT   = 0;

    // Interrupt status, clear and enable layout
    localparam int IRQ_TX_EMPTY     = 0;
    localparam int IRQ_RX_FULL      = 1;
    localparam int IRQ_RX_ERROR     = 2;
    localparam int IRQ_TX_DONE      = 3;
    localparam int IRQ_COUNT        = 4;

    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] MODE_RESET    = 8'h00;
    localparam logic [7:0] SC_MODE_RESET = 8'h00;
    localparam logic [3:0] IRQ_EN_RESET  = 4'h0;

    // Oversampling: sixteen ticks per bit, clock high in the second half
    localparam logic [3:0] OVS_HALF = 4'h7;
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam int         OVS_DIV_DEFAULT = 4;

    typedef enum {
        SCK_PORT,
        SCK_CLK_OUT,
        SCK_CLK_IN,
        SCK_FIX_LOW,
        SCK_FIX_HIGH
    } sck_fn_t;

endpackage : serial_ctrl_pkg

// *** verilog/level_sync.sv ***
`timescale 1ns/1ns
module level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : level_sync

// *** verilog/tick_divider.sv ***
`timescale 1ns/1ns
module tick_divider #(
    parameter int DIV = 4
) (
    input  wire logic clk,
    input  wire logic arst_n,
    output logic      tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_q;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cnt_q <= '0;
        else if (cnt_q == LAST)
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + CW'(1);
    end

    assign tick = (cnt_q == LAST);
endmodule : tick_divider

// *** verilog/serial_ctrl.sv ***
`timescale 1ns/1ns
module serial_ctrl #(
    parameter int OVS_DIV = serial_ctrl_pkg::OVS_DIV_DEFAULT
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rd_data,
    input  wire logic       sck_i,
    output logic            sck_o,
    output logic            sck_oe_n,
    output logic            sck_port_mode,
    input  wire logic       tx_empty_evt,
    input  wire logic       rx_full_evt,
    input  wire logic       rx_error_evt,
    input  wire logic       tx_done_evt,
    input  wire logic       rx_mpb_one_evt,
    output logic            tx_run,
    output logic            rx_run,
    output logic            tx_bit_tick,
    output logic            rx_bit_tick,
    output logic            rx_os_tick,
    output logic            addr_skip,
    output logic            tx_empty_irq,
    output logic            rx_full_irq,
    output logic            rx_error_irq,
    output logic            tx_done_irq,
    output logic            irq
);
    logic [7:0] ctrl_q;
    logic [7:0] mode_q;
    logic [7:0] sc_mode_q;
    logic [serial_ctrl_pkg::IRQ_COUNT-1:0] irq_stat_q;
    logic [serial_ctrl_pkg::IRQ_COUNT-1:0] irq_en_q;
    logic [serial_ctrl_pkg::IRQ_COUNT-1:0] irq_evt;
    logic [serial_ctrl_pkg::IRQ_COUNT-1:0] irq_req;
    logic [7:0] rd_data_q;
    logic [7:0] rd_d;
    logic [3:0] ovs_cnt_q;
    logic       sck_sync;
    logic       sck_prev_q;
    logic       sck_rise;
    logic       sck_fall;
    logic       int_tick;
    logic       os_tick;
    logic       clk_rise;
    logic       clk_fall;
    logic       int_level;
    logic       sync_mode;
    logic       smart_card;
    logic       block_xfer;
    logic       ext_clk;
    logic       ctrl_wr;
    logic       mode_wr;
    logic       sc_mode_wr;
    logic       irq_en_wr;
    logic       irq_clr_wr;
    logic [7:0] pin_stat;
    logic [1:0] clk_sel;
    serial_ctrl_pkg::sck_fn_t sck_fn;

    function automatic logic sel_hit(input logic [3:0] a, input logic [3:0] target);
        sel_hit = (a == target);
    endfunction : sel_hit

    level_sync #(
        .WIDTH (1)
    ) u_sck_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in (sck_i),
        .sync_out (sck_sync)
    );

    tick_divider #(
        .DIV (OVS_DIV)
    ) u_ovs_div (
        .clk    (clk),
        .arst_n (arst_n),
        .tick   (int_tick)
    );

    // Smart card framing is character based, so the synchronous bit means nothing there
    assign sync_mode  = mode_q[serial_ctrl_pkg::MODE_SYNC] && !smart_card;
    assign block_xfer = mode_q[serial_ctrl_pkg::MODE_BLOCK_XFER];
    assign smart_card = sc_mode_q[serial_ctrl_pkg::SC_MODE_SELECT];
    assign clk_sel    = {ctrl_q[serial_ctrl_pkg::CTRL_CLK_SEL_HI], ctrl_q[serial_ctrl_pkg::CTRL_CLK_SEL_LO]};
    assign ctrl_wr    = wr_en && sel_hit(addr, serial_ctrl_pkg::ADDR_CTRL);
    assign mode_wr    = wr_en && sel_hit(addr, serial_ctrl_pkg::ADDR_MODE);
    assign sc_mode_wr = wr_en && sel_hit(addr, serial_ctrl_pkg::ADDR_SC_MODE);
    assign irq_en_wr  = wr_en && sel_hit(addr, serial_ctrl_pkg::ADDR_IRQ_EN);
    assign irq_clr_wr = wr_en && sel_hit(addr, serial_ctrl_pkg::ADDR_IRQ_CLR);

    // Control register; address wake-up enable self-clears on a marked frame
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ctrl_q <= serial_ctrl_pkg::CTRL_RESET;
        else if (ctrl_wr)
            ctrl_q <= wr_data;
        else if (addr_skip && rx_mpb_one_evt)
            ctrl_q[serial_ctrl_pkg::CTRL_WAKE_EN] <= 1'b0;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            mode_q <= serial_ctrl_pkg::MODE_RESET;
        else if (mode_wr)
            mode_q <= wr_data;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            sc_mode_q <= serial_ctrl_pkg::SC_MODE_RESET;
        else if (sc_mode_wr)
            sc_mode_q <= wr_data;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            irq_en_q <= serial_ctrl_pkg::IRQ_EN_RESET;
        else if (irq_en_wr)
            irq_en_q <= wr_data[serial_ctrl_pkg::IRQ_COUNT-1:0];
    end

    // Pin function; decoded live so block mode follows select changes at once
    always_comb
    begin
        sck_fn = serial_ctrl_pkg::SCK_PORT;
        if (smart_card)
        begin
            if (block_xfer)
            begin
                unique case (clk_sel)
                    2'b00:   sck_fn = serial_ctrl_pkg::SCK_FIX_LOW;
                    2'b10:   sck_fn = serial_ctrl_pkg::SCK_FIX_HIGH;
                    default: sck_fn = serial_ctrl_pkg::SCK_CLK_OUT;
                endcase
            end
            else
            begin
                // Reserved 1x leaves the pin released rather than guessing a level
                unique case (clk_sel)
                    2'b01:   sck_fn = serial_ctrl_pkg::SCK_CLK_OUT;
                    default: sck_fn = serial_ctrl_pkg::SCK_PORT;
                endcase
            end
        end
        else if (sync_mode)
        begin
            if (clk_sel[1])
                sck_fn = serial_ctrl_pkg::SCK_CLK_IN;
            else
                sck_fn = serial_ctrl_pkg::SCK_CLK_OUT;
        end
        else
        begin
            unique case (clk_sel)
                2'b00:   sck_fn = serial_ctrl_pkg::SCK_PORT;
                2'b01:   sck_fn = serial_ctrl_pkg::SCK_CLK_OUT;
                default: sck_fn = serial_ctrl_pkg::SCK_CLK_IN;
            endcase
        end
    end

    assign ext_clk = (sck_fn == serial_ctrl_pkg::SCK_CLK_IN);

    // Edge finder reads only the second synchroniser stage
    // Each pin level must last more than one clk cycle to be seen, which bounds the external clock rate
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            sck_prev_q <= 1'b0;
        else
            sck_prev_q <= sck_sync;
    end

    assign sck_rise = sck_sync && !sck_prev_q;
    assign sck_fall = !sck_sync && sck_prev_q;

    // Async external clock is sixteen times the bit rate, so it feeds the oversampler
    always_comb
    begin
        if (!ext_clk)
            os_tick = int_tick;
        else if (!sync_mode)
            os_tick = sck_rise;
        else
            os_tick = 1'b0;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ovs_cnt_q <= 4'h0;
        else if (os_tick)
            ovs_cnt_q <= ovs_cnt_q + 4'h1;
    end

    // Internal bit clock: low for the first half of the bit, high for the second
    assign int_level = ovs_cnt_q[3];

    always_comb
    begin
        if (ext_clk && sync_mode)
        begin
            clk_rise = sck_rise;
            clk_fall = sck_fall;
        end
        else
        begin
            clk_rise = os_tick && (ovs_cnt_q == serial_ctrl_pkg::OVS_HALF);
            clk_fall = os_tick && (ovs_cnt_q == serial_ctrl_pkg::OVS_LAST);
        end
    end

    // Pin drive; output enable is active low
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sck_o    <= 1'b0;
            sck_oe_n <= 1'b1;
        end
        else
        begin
            unique case (sck_fn)
                serial_ctrl_pkg::SCK_CLK_OUT:
                begin
                    sck_o    <= int_level;
                    sck_oe_n <= 1'b0;
                end
                serial_ctrl_pkg::SCK_FIX_LOW:
                begin
                    sck_o    <= 1'b0;
                    sck_oe_n <= 1'b0;
                end
                serial_ctrl_pkg::SCK_FIX_HIGH:
                begin
                    sck_o    <= 1'b1;
                    sck_oe_n <= 1'b0;
                end
                serial_ctrl_pkg::SCK_CLK_IN,
                serial_ctrl_pkg::SCK_PORT:
                begin
                    sck_o    <= 1'b0;
                    sck_oe_n <= 1'b1;
                end
            endcase
        end
    end

    assign sck_port_mode = (sck_fn == serial_ctrl_pkg::SCK_PORT);

    // Transfer gating by the enables
    assign tx_run      = ctrl_q[serial_ctrl_pkg::CTRL_TX_EN];
    assign rx_run      = ctrl_q[serial_ctrl_pkg::CTRL_RX_EN];
    assign tx_bit_tick = tx_run && clk_fall;
    assign rx_bit_tick = rx_run && clk_rise;
    assign rx_os_tick  = rx_run && os_tick && !sync_mode;

    // Wake-up skipping only exists for async multiprocessor format
    assign addr_skip = ctrl_q[serial_ctrl_pkg::CTRL_WAKE_EN] && mode_q[serial_ctrl_pkg::MODE_MULTIPROC]
                       && !sync_mode && !smart_card && rx_run;

    // Events: receive events are not recorded while wake-up skipping is active
    always_comb
    begin
        irq_evt = '0;
        irq_evt[serial_ctrl_pkg::IRQ_TX_EMPTY] = tx_empty_evt && tx_run;
        irq_evt[serial_ctrl_pkg::IRQ_RX_FULL]  = rx_full_evt && rx_run && !addr_skip;
        irq_evt[serial_ctrl_pkg::IRQ_RX_ERROR] = rx_error_evt && rx_run && !addr_skip;
        irq_evt[serial_ctrl_pkg::IRQ_TX_DONE]  = tx_done_evt && tx_run;
    end

    // Sticky status: a new event in the clear cycle survives the clear
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            irq_stat_q <= '0;
        else if (irq_clr_wr)
            irq_stat_q <= (irq_stat_q & ~wr_data[serial_ctrl_pkg::IRQ_COUNT-1:0]) | irq_evt;
        else
            irq_stat_q <= irq_stat_q | irq_evt;
    end

    always_comb
    begin
        irq_req = irq_stat_q & irq_en_q;
        irq_req[serial_ctrl_pkg::IRQ_TX_EMPTY] = irq_req[serial_ctrl_pkg::IRQ_TX_EMPTY]
            && ctrl_q[serial_ctrl_pkg::CTRL_TX_IRQ_EN];
        irq_req[serial_ctrl_pkg::IRQ_RX_FULL]  = irq_req[serial_ctrl_pkg::IRQ_RX_FULL]
            && ctrl_q[serial_ctrl_pkg::CTRL_RX_IRQ_EN];
        irq_req[serial_ctrl_pkg::IRQ_RX_ERROR] = irq_req[serial_ctrl_pkg::IRQ_RX_ERROR]
            && ctrl_q[serial_ctrl_pkg::CTRL_RX_IRQ_EN];
        irq_req[serial_ctrl_pkg::IRQ_TX_DONE]  = irq_req[serial_ctrl_pkg::IRQ_TX_DONE]
            && ctrl_q[serial_ctrl_pkg::CTRL_TX_DONE_EN];
    end

    assign tx_empty_irq = irq_req[serial_ctrl_pkg::IRQ_TX_EMPTY];
    assign rx_full_irq  = irq_req[serial_ctrl_pkg::IRQ_RX_FULL];
    assign rx_error_irq = irq_req[serial_ctrl_pkg::IRQ_RX_ERROR];
    assign tx_done_irq  = irq_req[serial_ctrl_pkg::IRQ_TX_DONE];
    assign irq          = |irq_req;

    // Pin status lets software watch the raw pin while it is released as a port
    assign pin_stat = {3'h0, addr_skip, sck_sync, !sck_oe_n, sck_o, ext_clk};

    // Read mux; clear register is write-only and reads zero like unmapped space
    always_comb
    begin
        rd_d = 8'h00;
        unique case (addr)
            serial_ctrl_pkg::ADDR_CTRL:     rd_d = ctrl_q;
            serial_ctrl_pkg::ADDR_MODE:     rd_d = mode_q;
            serial_ctrl_pkg::ADDR_SC_MODE:  rd_d = sc_mode_q;
            serial_ctrl_pkg::ADDR_IRQ_STAT: rd_d = {4'h0, irq_stat_q};
            serial_ctrl_pkg::ADDR_IRQ_EN:   rd_d = {4'h0, irq_en_q};
            serial_ctrl_pkg::ADDR_PIN_STAT: rd_d = pin_stat;
            default:                        rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rd_data_q <= 8'h00;
        else if (rd_en)
            rd_data_q <= rd_d;
        else
            rd_data_q <= 8'h00;
    end

    // Read data return to zero after one cycle so a stale word never looks fresh
    assign rd_data = rd_data_q;

endmodule : serial_ctrl

// *** tb/serial_ctrl_assertions.sv ***
`timescale 1ns/1ns
module serial_ctrl_assertions #(
    parameter int OVS_DIV = 4
) (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic       wr_en,
    input wire logic       sck_o,
    input wire logic       sck_oe_n,
    input wire logic       sck_port_mode,
    input wire logic       tx_run,
    input wire logic       rx_run,
    input wire logic       tx_bit_tick,
    input wire logic       rx_bit_tick,
    input wire logic       addr_skip,
    input wire logic       tx_empty_irq,
    input wire logic       rx_full_irq,
    input wire logic       rx_error_irq,
    input wire logic       irq
);
    // Half a bit clock plus the output register and one cycle of phase slack
    localparam int HALF = 8 * OVS_DIV + 2;
    logic [7:0] ctrl_q;
    logic [7:0] mode_q;
    logic       sc_q;
    logic       sck_prev_q;
    logic [7:0] hold_q;
    logic [1:0] sel;
    logic       gm;
    logic       syn;
    logic       port_c;
    logic       out_c;
    logic       in_c;
    logic       low_c;
    logic       high_c;

    // Shadow copy; the wake bit may self-clear in the design, so it is never checked here
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q <= 8'h00;
            mode_q <= 8'h00;
            sc_q   <= 1'b0;
        end
        else if (wr_en)
        begin
            if (addr == serial_ctrl_pkg::ADDR_CTRL) ctrl_q <= wr_data;
            if (addr == serial_ctrl_pkg::ADDR_MODE) mode_q <= wr_data;
            if (addr == serial_ctrl_pkg::ADDR_SC_MODE) sc_q <= wr_data[0];
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hold_q     <= 8'h00;
            sck_prev_q <= 1'b0;
        end
        else
        begin
            sck_prev_q <= sck_o;
            hold_q     <= (out_c && sck_o == sck_prev_q) ? hold_q + 8'h01 : 8'h00;
        end
    end

    assign sel    = ctrl_q[1:0];
    assign gm     = mode_q[serial_ctrl_pkg::MODE_BLOCK_XFER];
    assign syn    = mode_q[serial_ctrl_pkg::MODE_SYNC] && !sc_q;
    assign port_c = sc_q ? (!gm && sel != 2'h1) : (!syn && sel == 2'h0);
    assign out_c  = sc_q ? (sel == 2'h1 || (gm && sel == 2'h3)) : (syn ? !sel[1] : sel == 2'h1);
    assign in_c   = !sc_q && sel[1];
    assign low_c  = sc_q && gm && sel == 2'h0;
    assign high_c = sc_q && gm && sel == 2'h2;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_tx_run_follows: assert property (tx_run == ctrl_q[5])
        else $error("tx_run differs from enable bit");
    a_rx_run_follows: assert property (rx_run == ctrl_q[4])
        else $error("rx_run differs from enable bit");
    a_ticks_need_run: assert property ((tx_bit_tick -> tx_run) && (rx_bit_tick -> rx_run))
        else $error("bit tick without run");
    a_pin_released: assert property ($past(port_c) && port_c |-> sck_oe_n && sck_port_mode)
        else $error("clock pin not released");
    a_ext_clk_input: assert property ($past(in_c) && in_c |-> sck_oe_n && !sck_port_mode)
        else $error("clock pin not an input");
    a_clk_out_drive: assert property ($past(out_c) && out_c |-> !sck_oe_n)
        else $error("clock pin not driven");
    a_clk_out_toggles: assert property (hold_q <= HALF)
        else $error("clock output stuck");
    a_fixed_low: assert property ($past(low_c) && low_c |-> !sck_oe_n && !sck_o)
        else $error("clock pin not fixed low");
    a_fixed_high: assert property ($past(high_c) && high_c |-> !sck_oe_n && sck_o)
        else $error("clock pin not fixed high");
    a_tx_irq_gate: assert property (tx_empty_irq |-> ctrl_q[7])
        else $error("tx request while disabled");
    a_rx_irq_gate: assert property (rx_full_irq || rx_error_irq |-> ctrl_q[6])
        else $error("rx request while disabled");
    a_wake_scope: assert property (addr_skip |-> mode_q[2] && !mode_q[7])
        else $error("skipping outside multiprocessor async");
    a_reset_quiet: assert property ($rose(arst_n) |-> sck_oe_n && !irq && !tx_run && !rx_run)
        else $error("not quiet after reset");
endmodule : serial_ctrl_assertions

bind serial_ctrl serial_ctrl_assertions #(.OVS_DIV(OVS_DIV)) u_chk (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .sck_o(sck_o),
    .sck_oe_n(sck_oe_n), .sck_port_mode(sck_port_mode), .tx_run(tx_run), .rx_run(rx_run),
    .tx_bit_tick(tx_bit_tick), .rx_bit_tick(rx_bit_tick), .addr_skip(addr_skip),
    .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq), .irq(irq)
);

// *** tb/sck_peer.sv ***
`timescale 1ns/1ns
module sck_peer (
    input  wire logic run,
    output logic      clk_out
);
    // Parks low between bursts; the 3 ns lag keeps its edges off the sampling clock
    initial
    begin
        clk_out = 1'b0;
        forever
        begin
            wait (run);
            #3;
            while (run)
            begin
                clk_out = 1'b1;
                #80;
                clk_out = 1'b0;
                #80;
            end
        end
    end
endmodule : sck_peer

// *** tb/tb_serial_ctrl.sv ***
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; \
    if ((g) !== (e)) begin bad_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_serial_ctrl;
    localparam int DIV = 2;
    logic        clk;
    logic        arst_n;
    logic [3:0]  addr;
    logic [7:0]  wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  rd_data;
    logic        sck_o;
    logic        sck_oe_n;
    logic        sck_port_mode;
    logic [3:0]  evt;
    logic        mpb_evt;
    logic        tx_run;
    logic        rx_run;
    logic        tx_bit_tick;
    logic        rx_bit_tick;
    logic        rx_os_tick;
    logic        addr_skip;
    logic [3:0]  irqs;
    logic        irq;
    logic        peer_run;
    logic        peer_clk;
    logic        seen;
    logic [19:0] e;
    int          bad_count;
    int          samples_checked;
    int          cycles;
    int          n_os;
    int          n_rxb;
    int          n_txb;
    int          n;
    // Per mode: {mode reg, smart card select, control, pin: 0 port 1 in 2 clock 3 low 4 high}
    logic [19:0] modes [14] = '{20'h00000, 20'h00012, 20'h00021, 20'h80002, 20'h80012,
        20'h80021, 20'h00100, 20'h00112, 20'h00120, 20'h40103, 20'h40112,
        20'h40124, 20'h40132, 20'h40103};
    logic [7:0]  irq_on [4] = '{8'hA0, 8'h50, 8'h50, 8'h24};
    logic [7:0]  run_on [4] = '{8'h20, 8'h10, 8'h10, 8'h20};

    // Released pin follows the peer clock, which parks low between bursts
    wire sck_pin = !sck_oe_n ? sck_o : peer_clk;

    serial_ctrl #(.OVS_DIV(DIV)) dut (
        .clk(clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .sck_i(sck_pin), .sck_o(sck_o), .sck_oe_n(sck_oe_n), .sck_port_mode(sck_port_mode),
        .tx_empty_evt(evt[0]), .rx_full_evt(evt[1]), .rx_error_evt(evt[2]), .tx_done_evt(evt[3]),
        .rx_mpb_one_evt(mpb_evt), .tx_run(tx_run), .rx_run(rx_run), .tx_bit_tick(tx_bit_tick),
        .rx_bit_tick(rx_bit_tick), .rx_os_tick(rx_os_tick), .addr_skip(addr_skip),
        .tx_empty_irq(irqs[0]), .rx_full_irq(irqs[1]), .rx_error_irq(irqs[2]), .tx_done_irq(irqs[3]), .irq(irq)
    );

    sck_peer peer (.run(peer_run), .clk_out(peer_clk));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        n_os  += int'(rx_os_tick);
        n_rxb += int'(rx_bit_tick);
        n_txb += int'(tx_bit_tick);
        cycles++;
        if (cycles == 10000)
        begin
            bad_count++;
            results();
        end
    end

    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : wait_cyc

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en   <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] x);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        `CHK("rd_data", x, rd_data);
    endtask : rd

    task automatic pulse(input logic [3:0] v, input logic m);
        @(posedge clk);
        evt     <= v;
        mpb_evt <= m;
        @(posedge clk);
        evt     <= 4'h0;
        mpb_evt <= 1'b0;
    endtask : pulse

    task automatic burst(input logic [7:0] md, input logic [7:0] ct, input int os, input int rb, input int tb);
        wr(serial_ctrl_pkg::ADDR_MODE, md);
        wr(serial_ctrl_pkg::ADDR_CTRL, ct);
        wait_cyc(4);
        n_os  = 0;
        n_rxb = 0;
        n_txb = 0;
        @(posedge clk);
        peer_run <= 1'b1;
        repeat (256) @(posedge clk);
        peer_run <= 1'b0;
        wait_cyc(12);
        `CHK("os ticks", os, n_os);
        if (rb >= 0) `CHK("rx ticks", rb, n_rxb);
        `CHK("tx ticks", tb, n_txb);
    endtask : burst

    task automatic results;
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    initial
    begin
        arst_n   = 1'b0;
        addr     = 4'h0;
        wr_data  = 8'h00;
        wr_en    = 1'b0;
        rd_en    = 1'b0;
        evt      = 4'h0;
        mpb_evt  = 1'b0;
        peer_run = 1'b0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rd(i[3:0], 8'h00);
        wr(4'h7, 8'h5A);
        rd(4'h7, 8'h00);
        wr(serial_ctrl_pkg::ADDR_CTRL, 8'hF7);
        rd(serial_ctrl_pkg::ADDR_CTRL, 8'hF7);
        `CHK("tx_run", 1'b1, tx_run);
        `CHK("rx_run", 1'b1, rx_run);
        `CHK("addr_skip", 1'b0, addr_skip);
        wr(serial_ctrl_pkg::ADDR_IRQ_EN, 8'h0F);
        for (int i = 0; i < 4; i++)
        begin
            wr(serial_ctrl_pkg::ADDR_CTRL, 8'h00);
            pulse(4'h1 << i, 1'b0);
            rd(serial_ctrl_pkg::ADDR_IRQ_STAT, 8'h00);
            wr(serial_ctrl_pkg::ADDR_CTRL, run_on[i]);
            pulse(4'h1 << i, 1'b0);
            rd(serial_ctrl_pkg::ADDR_IRQ_STAT, 8'h01 << i);
            `CHK("irq", 1'b0, irq);
            wr(serial_ctrl_pkg::ADDR_CTRL, irq_on[i]);
            wait_cyc(1);
            `CHK("irqs", 4'h1 << i, irqs);
            `CHK("irq", 1'b1, irq);
            wr(serial_ctrl_pkg::ADDR_IRQ_EN, 8'h00);
            wait_cyc(1);
            `CHK("irq", 1'b0, irq);
            wr(serial_ctrl_pkg::ADDR_IRQ_EN, 8'h0F);
            wr(serial_ctrl_pkg::ADDR_IRQ_CLR, 8'h01 << i);
            rd(serial_ctrl_pkg::ADDR_IRQ_STAT, 8'h00);
            `CHK("irq", 1'b0, irq);
        end
        wr(serial_ctrl_pkg::ADDR_MODE, 8'h04);
        wr(serial_ctrl_pkg::ADDR_CTRL, 8'h18);
        wait_cyc(1);
        `CHK("addr_skip", 1'b1, addr_skip);
        pulse(4'h2, 1'b0);
        rd(serial_ctrl_pkg::ADDR_IRQ_STAT, 8'h00);
        pulse(4'h0, 1'b1);
        rd(serial_ctrl_pkg::ADDR_CTRL, 8'h10);
        `CHK("addr_skip", 1'b0, addr_skip);
        wr(serial_ctrl_pkg::ADDR_MODE, 8'h84);
        wr(serial_ctrl_pkg::ADDR_CTRL, 8'h18);
        wait_cyc(1);
        `CHK("addr_skip", 1'b0, addr_skip);
        for (int i = 0; i < 14; i++)
        begin
            e = modes[i];
            wr(serial_ctrl_pkg::ADDR_MODE, e[19:12]);
            wr(serial_ctrl_pkg::ADDR_SC_MODE, {4'h0, e[11:8]});
            wr(serial_ctrl_pkg::ADDR_CTRL, {4'h0, e[7:4]});
            wait_cyc(3);
            `CHK("sck_oe_n", e[3:0] < 4'h2, sck_oe_n);
            `CHK("sck_port_mode", e[3:0] == 4'h0, sck_port_mode);
            if (e[3:0] > 4'h2) `CHK("sck_o", e[3:0] == 4'h4, sck_o);
            seen = sck_o;
            n = 0;
            while (e[3:0] == 4'h2 && sck_o === seen && n < 8 * DIV + 2)
            begin
                wait_cyc(1);
                n++;
            end
            if (e[3:0] == 4'h2) `CHK("sck_o toggle", 1'b1, sck_o !== seen);
        end
        // Smart card with the synchronous bit set still oversamples on the internal clock
        wr(serial_ctrl_pkg::ADDR_MODE, 8'hC0);
        wr(serial_ctrl_pkg::ADDR_CTRL, 8'h11);
        wait_cyc(1);
        n_os = 0;
        wait_cyc(8 * DIV);
        `CHK("sc os ticks", 8, n_os);
        wr(serial_ctrl_pkg::ADDR_SC_MODE, 8'h00);
        burst(8'h00, 8'h12, 16, -1, 0);
        burst(8'h00, 8'h02, 0, 0, 0);
        burst(8'h80, 8'h32, 0, 16, 16);
        burst(8'h80, 8'h22, 0, 0, 16);
        results();
    end
endmodule : tb_serial_ctrl
